// >>> common/sfu_pkg.sv
// constants, types and decode functions for the floating operand unpacker
`default_nettype none
package sfu_pkg;
	localparam int OP_W       = 32;
	localparam int EXP_W      = 8;
	localparam int FRAC_W     = 24;
	localparam int SIGN_BIT   = 15;
	localparam int EXP_HI     = 14;
	localparam int EXP_LO     = 7;
	localparam int FLO_HI     = 6;
	localparam int FLO_LO     = 0;
	localparam int FHI_HI     = 31;
	localparam int FHI_LO     = 16;
	localparam logic [EXP_W-1:0] EXP_BIAS = 8'h80;
	localparam logic [EXP_W-1:0] EXP_ZERO = 8'h00;
	localparam logic [FRAC_W-1:0] FRAC_RST = 24'h00_0000;
	localparam logic [OP_W-1:0]  ADDR_RST = 32'h0000_0000;

	typedef enum logic [1:0] {
		SFU_RUN   = 2'b01,
		SFU_FAULT = 2'b10
	} sfu_state_e;

	// hidden bit on top, then bits 6..0, then bits 31..16
	function automatic logic [FRAC_W-1:0] sfu_frac(
		input logic [OP_W-1:0] op
	);
		sfu_frac = {1'b1, op[FLO_HI:FLO_LO], op[FHI_HI:FHI_LO]};
	endfunction

	// subtracting the bias of 128 modulo 256 only flips the top bit
	function automatic logic [EXP_W-1:0] sfu_true_exp(
		input logic [EXP_W-1:0] code
	);
		sfu_true_exp = code ^ EXP_BIAS;
	endfunction
endpackage
`default_nettype wire

// >>> common/sfu_fields_if.sv
// decoded operand fields passed from the splitter to the unpacker top
`timescale 1ns/100ps
`default_nettype none
interface sfu_fields_if;
	import sfu_pkg::*;
	logic [OP_W-1:0]   operand;
	logic              sign;
	logic [EXP_W-1:0]  exp_code;
	logic [EXP_W-1:0]  exp_true;
	logic [FRAC_W-1:0] frac;
	logic              is_zero;
	logic              is_rsvd;

	modport split (
		input  operand,
		output sign, exp_code, exp_true, frac, is_zero, is_rsvd
	);
	modport top (
		output operand,
		input  sign, exp_code, exp_true, frac, is_zero, is_rsvd
	);
endinterface
`default_nettype wire

// >>> hdl/sfu_field_split.sv
// combinational split of a 32-bit floating operand into its fields
`timescale 1ns/100ps
`default_nettype none
module sfu_field_split
	import sfu_pkg::*;
(
	sfu_fields_if.split f
);
	logic exp_is_zero;

	assign exp_is_zero = (f.exp_code == EXP_ZERO);
	assign f.sign      = f.operand[SIGN_BIT];
	assign f.exp_code  = f.operand[EXP_HI:EXP_LO];
	assign f.exp_true  = sfu_true_exp(f.exp_code);
	// a true zero carries no fraction, so the hidden bit is not forced in
	assign f.frac      = f.is_zero ? FRAC_RST :
		sfu_frac(f.operand);
	assign f.is_zero   = exp_is_zero && !f.sign;
	assign f.is_rsvd   = exp_is_zero && f.sign;
endmodule
`default_nettype wire

// >>> hdl/sfu_unpack.sv
// floating operand unpacker: handshake, result registers and fault hold
// Overview of operation
// - operand is four bytes, bit 0 first; its byte address travels along
// - sign comes from operand bit 15, one means negative
// - exponent is bits 14 down to 7, biased by 128
// - fraction is 24 bits with the unstored top bit restored
// - fraction order is bits 6 down to 0, then 31 down to 16
// - exponent codes map to true exponents as code minus 128
// - exponent zero with sign zero is the value zero
// - exponent zero with sign one raises a reserved-operand fault
// - fault leaves all results untouched so a restart is correct
`timescale 1ns/100ps
`default_nettype none
module sfu_unpack
	import sfu_pkg::*;
(
	input  wire logic                     core_clk,
	input  wire logic                     arst_n,
	input  wire logic                     op_valid,
	output logic                          op_ready,
	input  wire logic [OP_W-1:0]          op_data,
	input  wire logic [OP_W-1:0]          op_addr,
	output logic                          res_valid,
	input  wire logic                     res_ready,
	output logic                          res_sign,
	output logic [EXP_W-1:0]              res_exp_code,
	output logic [EXP_W-1:0]              res_exp_true,
	output logic [FRAC_W-1:0]             res_frac,
	output logic                          res_zero,
	output logic [OP_W-1:0]               res_addr,
	output logic                          flt_req,
	output logic [OP_W-1:0]               flt_addr,
	input  wire logic                     flt_ack
);
	sfu_fields_if       fld ();
	sfu_state_e         state_r;
	logic               take;
	logic               take_ok;
	logic               take_bad;
	logic               res_valid_r;
	logic               res_sign_r;
	logic [EXP_W-1:0]   res_exp_code_r;
	logic [EXP_W-1:0]   res_exp_true_r;
	logic [FRAC_W-1:0]  res_frac_r;
	logic               res_zero_r;
	logic [OP_W-1:0]    res_addr_r;
	logic               flt_req_r;
	logic [OP_W-1:0]    flt_addr_r;

	// the splitter is purely combinational, so all fields line up with a take
	assign fld.operand = op_data;

	sfu_field_split u_split (
		.f (fld.split)
	);

	// a new operand waits while a fault is open or the last result is unread
	assign op_ready = (state_r == SFU_RUN) &&
		(!res_valid_r || res_ready);
	assign take     = op_valid && op_ready;
	assign take_ok  = take && !fld.is_rsvd;
	assign take_bad = take && fld.is_rsvd;

	// only the handler's acknowledge or a reset leaves the fault state
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= SFU_RUN;
		end else begin
			unique case (state_r)
				SFU_RUN: begin
					if (take_bad) begin
						state_r <= SFU_FAULT;
					end
				end
				SFU_FAULT: begin
					if (flt_ack) begin
						state_r <= SFU_RUN;
					end
				end
				default: begin
					state_r <= SFU_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			res_valid_r <= 1'b0;
		end else if (take) begin
			// a reserved operand produces no result at all
			res_valid_r <= !fld.is_rsvd;
		end else if (res_ready) begin
			res_valid_r <= 1'b0;
		end
	end

	// fields load only on a good operand, so a fault disturbs nothing
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			res_sign_r     <= 1'b0;
			res_exp_code_r <= EXP_ZERO;
			res_exp_true_r <= EXP_ZERO;
			res_frac_r     <= FRAC_RST;
			res_zero_r     <= 1'b0;
			res_addr_r     <= ADDR_RST;
		end else if (take_ok) begin
			res_sign_r     <= fld.sign;
			res_exp_code_r <= fld.exp_code;
			res_exp_true_r <= fld.exp_true;
			res_frac_r     <= fld.frac;
			res_zero_r     <= fld.is_zero;
			res_addr_r     <= op_addr;
		end
	end

	// the faulting address is kept so the handler can restart the operand
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			flt_req_r  <= 1'b0;
			flt_addr_r <= ADDR_RST;
		end else if (take_bad) begin
			flt_req_r  <= 1'b1;
			flt_addr_r <= op_addr;
		end else if (flt_ack) begin
			flt_req_r  <= 1'b0;
		end
	end

	assign res_valid    = res_valid_r;
	assign res_sign     = res_sign_r;
	assign res_exp_code = res_exp_code_r;
	assign res_exp_true = res_exp_true_r;
	assign res_frac     = res_frac_r;
	assign res_zero     = res_zero_r;
	assign res_addr     = res_addr_r;
	assign flt_req      = flt_req_r;
	assign flt_addr     = flt_addr_r;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);
	// checks idle while reset is low, all on the core clock

	// decoded from the operand pins so the checks do not lean on the splitter
	logic in_exp0;
	assign in_exp0 = (op_data[EXP_HI:EXP_LO] == EXP_ZERO);

	sign_map_a: assert property (
		take_ok |=> res_valid && res_sign == $past(op_data[SIGN_BIT]))
		else $error("sign not taken from bit 15");

	exp_map_a: assert property (
		take_ok |=> res_exp_code == $past(op_data[EXP_HI:EXP_LO]))
		else $error("exponent code not taken from bits 14 to 7");

	frac_order_a: assert property (
		take_ok && !in_exp0 |=> res_frac ==
			{1'b1, $past(op_data[FLO_HI:FLO_LO]), $past(op_data[FHI_HI:FHI_LO])})
		else $error("fraction bits out of order");

	hidden_bit_a: assert property (
		res_valid && !res_zero |-> res_frac[FRAC_W-1])
		else $error("hidden fraction bit missing");

	true_exp_a: assert property (
		res_valid |-> $signed(res_exp_true) ==
			$signed({1'b0, res_exp_code}) - 9'sh080)
		else $error("true exponent is not code minus 128");

	zero_class_a: assert property (
		take && in_exp0 && !op_data[SIGN_BIT] |=> res_valid && res_zero)
		else $error("zero operand not flagged");

	rsvd_fault_a: assert property (
		take && in_exp0 && op_data[SIGN_BIT] |=> flt_req && !res_valid
			&& flt_addr == $past(op_addr))
		else $error("reserved operand did not fault");

	fault_hold_a: assert property (
		flt_req && !flt_ack |=> flt_req && !op_ready && $stable(res_frac)
			&& $stable(res_exp_code) && $stable(res_sign))
		else $error("state disturbed while fault open");

	aligned_flags_a: assert property (
		res_valid |-> res_zero == (res_exp_code == EXP_ZERO && !res_sign))
		else $error("zero flag not aligned with fields");

	addr_carry_a: assert property (
		take_ok |=> res_addr == $past(op_addr))
		else $error("operand address not carried");

	fault_blocks_a: assert property (
		flt_req |-> !op_ready)
		else $error("operand accepted while fault open");

	result_hold_a: assert property (
		res_valid && !res_ready |=> res_valid && $stable(res_frac)
			&& $stable(res_addr) && $stable(res_exp_true))
		else $error("result changed before it was consumed");

	fault_clear_a: assert property (
		flt_req && flt_ack |=> !flt_req && op_ready)
		else $error("fault not cleared by acknowledge");

	zero_frac_a: assert property (
		res_valid && res_zero |-> res_frac == FRAC_RST)
		else $error("zero operand carries a fraction");

	rsvd_no_load_a: assert property (
		take_bad |=> !res_valid && $stable(res_exp_true)
			&& $stable(res_addr) && $stable(res_zero))
		else $error("reserved operand disturbed result fields");

	one_answer_a: assert property (
		!(res_valid && flt_req))
		else $error("result and fault raised together");

	good_op_c: cover property (take_ok ##1 res_valid && res_ready);
	zero_op_c: cover property (take_ok && fld.is_zero ##1 res_zero);
	fault_c:   cover property (take_bad ##1 flt_req ##[1:4] flt_ack);
	stall_c:   cover property (res_valid && !res_ready && op_valid);
	back_c:    cover property (take_ok ##1 take_ok);
endmodule
`default_nettype wire

// >>> dv/sfu_partner.sv
// far-side model: result consumer and fault handler with settable delay
`timescale 1ns/100ps
`default_nettype none
module sfu_partner (
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	input  wire logic       res_valid,
	input  wire logic       flt_req,
	input  wire logic [3:0] dly,
	output logic            res_ready,
	output logic            flt_ack
);
	logic [3:0] cnt_r;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			cnt_r <= 4'h0;
		// restart after each handshake so every answer waits the delay
		else if (!(res_valid || flt_req) || flt_ack ||
				(res_valid && res_ready))
			cnt_r <= 4'h0;
		else if (cnt_r < dly)
			cnt_r <= cnt_r + 4'h1;
	end
	// delay 0 keeps ready high so takes can run back to back
	assign res_ready = (cnt_r >= dly);
	// fault is acknowledged once the delay has run out, just like a result
	assign flt_ack   = flt_req && (cnt_r >= dly);
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench for the floating operand unpacker
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
	$display("mismatch %s exp %h got %h", nm, ex, got); num_errors++; end end
module testbench;
	import sfu_pkg::*;
	typedef struct packed {
		logic [OP_W-1:0]   op;
		logic              s;
		logic [EXP_W-1:0]  c;
		logic [EXP_W-1:0]  t;
		logic [FRAC_W-1:0] fr;
		logic              z;
		logic              f;
	} sfu_row_s;
	localparam sfu_row_s ROWS [8] = '{
		'{32'hABCD_C0B5, 1'b1, 8'h81, 8'h01, 24'hB5_ABCD, 1'b0, 1'b0},
		'{32'h5555_0012, 1'b0, 8'h00, 8'h80, 24'h00_0000, 1'b1, 1'b0},
		'{32'h0000_7FFF, 1'b0, 8'hFF, 8'h7F, 24'hFF_0000, 1'b0, 1'b0},
		'{32'hFFFF_0080, 1'b0, 8'h01, 8'h81, 24'h80_FFFF, 1'b0, 1'b0},
		'{32'h2222_807F, 1'b1, 8'h00, 8'h00, 24'h00_0000, 1'b0, 1'b1},
		'{32'h2222_817F, 1'b1, 8'h02, 8'h82, 24'hFF_2222, 1'b0, 1'b0},
		'{32'h0000_4000, 1'b0, 8'h80, 8'h00, 24'h80_0000, 1'b0, 1'b0},
		'{32'h1111_8000, 1'b1, 8'h00, 8'h00, 24'h00_0000, 1'b0, 1'b1}};
	logic              core_clk, arst_n, op_valid, op_ready, res_valid;
	logic              res_ready, res_sign, res_zero, flt_req, flt_ack;
	logic [OP_W-1:0]   op_data, op_addr, res_addr, flt_addr, ea;
	logic [EXP_W-1:0]  res_exp_code, res_exp_true;
	logic [FRAC_W-1:0] res_frac;
	logic [3:0]        dly;
	sfu_row_s          e, last, exp_q[$];
	logic [OP_W-1:0]   addr_q[$];
	int                num_errors, checks;

	sfu_unpack dut (.core_clk, .arst_n, .op_valid, .op_ready, .op_data,
		.op_addr, .res_valid, .res_ready, .res_sign, .res_exp_code,
		.res_exp_true, .res_frac, .res_zero, .res_addr, .flt_req,
		.flt_addr, .flt_ack);
	sfu_partner far (.core_clk, .arst_n, .res_valid, .flt_req, .dly,
		.res_ready, .flt_ack);

	always #2 core_clk = ~core_clk;

	task end_sim;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// offer at the current edge, return at the edge that takes it
	task xfer(input sfu_row_s r, input logic [OP_W-1:0] a);
		int n;
		op_valid <= 1'b1;
		op_data <= r.op;
		op_addr <= a;
		n = 0;
		@(negedge core_clk);
		while (op_ready !== 1'b1) begin
			if (++n > 50) begin
				num_errors++;
				end_sim();
			end
			@(negedge core_clk);
		end
		@(posedge core_clk);
		exp_q.push_back(r);
		addr_q.push_back(a);
	endtask

	task drain;
		for (int n = 0; n < 50 && exp_q.size() != 0; n++)
			@(negedge core_clk);
		if (exp_q.size() != 0) begin
			num_errors++;
			end_sim();
		end
	endtask

	// results are judged at the cycle the far side consumes them
	always @(negedge core_clk) if (arst_n === 1'b1) begin
		if (flt_req || (res_valid && !res_ready))
			`CHK("ready", 1'b0, op_ready);
		if ((res_valid && res_ready) || (flt_req && flt_ack)) begin
			if (exp_q.size() != 0) begin
				e = exp_q.pop_front();
				ea = addr_q.pop_front();
			end else
				num_errors++;
			`CHK("fault", e.f, flt_req);
			if (flt_req) begin
				`CHK("flt_addr", ea, flt_addr);
				`CHK("held_frac", last.fr, res_frac);
			end else begin
				`CHK("sign", e.s, res_sign);
				`CHK("code", e.c, res_exp_code);
				`CHK("true", e.t, res_exp_true);
				`CHK("frac", e.fr, res_frac);
				`CHK("zero", e.z, res_zero);
				`CHK("addr", ea, res_addr);
				last = e;
			end
		end
	end

	initial begin
		core_clk = 0;
		arst_n = 0;
		op_valid = 0;
		op_data = '0;
		op_addr = '0;
		dly = 0;
		last = '0;
		repeat (5) @(posedge core_clk);
		arst_n <= 1'b1;
		@(negedge core_clk);
		`CHK("rst_flt", 1'b0, flt_req);
		$display("test reset done");
		for (int p = 0; p < 2; p++) begin
			@(posedge core_clk);
			dly <= p ? 4'h3 : 4'h0;
			for (int i = 0; i < 8; i++)
				xfer(ROWS[i], 32'h0000_1000 + 32'(i * 4));
			op_valid <= 1'b0;
			drain();
			$display("test rows pace %0d done", p);
		end
		// reset while a fault waits: nothing may survive it
		@(posedge core_clk);
		dly <= 4'hF;
		xfer(ROWS[4], 32'h0000_2000);
		op_valid <= 1'b0;
		repeat (3) @(negedge core_clk);
		`CHK("flt_open", 1'b1, flt_req);
		@(posedge core_clk);
		arst_n <= 1'b0;
		@(negedge core_clk);
		`CHK("rst_mid", 3'b001, {flt_req, res_valid, op_ready});
		exp_q.delete();
		addr_q.delete();
		last = '0;
		@(posedge core_clk);
		arst_n <= 1'b1;
		dly <= 4'h0;
		xfer(ROWS[5], 32'h0000_2000);
		op_valid <= 1'b0;
		drain();
		$display("test mid reset done");
		end_sim();
	end
endmodule
`default_nettype wire
